// File: verilog/mft_consts.svh
`ifndef MFT_CONSTS_SVH
`define MFT_CONSTS_SVH

// ----------------------------------------------------------------
// register select codes on the cpu port
// ----------------------------------------------------------------
`define SEL_EVENT_CTRL 3'h0
`define SEL_SETUP_CTRL 3'h1
`define SEL_COMPARE_A 3'h2
`define SEL_COMPARE_B 3'h3
`define SEL_CAPTURE 3'h4

// ----------------------------------------------------------------
// timer_event_control bit positions
// ----------------------------------------------------------------
`define EV_CAPTURE_B_FLAG 7
`define EV_CAPTURE_A_FLAG 6
`define EV_CAPTURE_IRQ_EN 5
`define EV_COMPARE_B_FLAG 4
`define EV_COMPARE_A_FLAG 3
`define EV_COMPARE_IRQ_EN 2
`define EV_WRAP_FLAG 1
`define EV_WRAP_IRQ_EN 0

// ----------------------------------------------------------------
// timer_setup_control field positions
// ----------------------------------------------------------------
`define SU_CAPTURE_EDGE 6
`define SU_EVENT_EDGE 5
`define SU_PRESCALE_HI 4
`define SU_PRESCALE_LO 2
`define SU_MODE_HI 1
`define SU_MODE_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_EVENT_CTRL 8'h00
`define RST_SETUP_CTRL 8'h00
`define RST_COUNT 16'h0000
`define RST_COMPARE 16'h0000

`endif

// File: verilog/mft_pkg.sv
`default_nettype none
package mft_pkg;

  typedef enum logic [1:0] {
    MODE_SOFT = 2'b00,
    MODE_PWM = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_EVENT = 2'b11
  } mode_e;

endpackage : mft_pkg
`default_nettype wire

// File: verilog/multi_function_timer.sv
// Operation
// - pwm counts to the active compare, toggles, restarts
// - active compare alternates a and b
// - pwm clock is prescaled system clock
// - software timer is pwm without toggling
// - separate flags for each event type
// - event mode counts selected external edges
// - capture mode counter runs free
// - capture mode match on a toggles, flags
// - capture mode prescaler from three-bit field
// - capture a edge loads capture register
// - capture b edge loads compare b
// - capture edge selectable, sets flag
// - wrap from max sets wrap flag
// - two eight-bit control registers
// - event control register bit layout
// - capture flags sticky until cleared
// - compare flags set only when active
// - capture enable gates capture interrupts
// - compare enable gates compare interrupts
// - wrap enable gates wrap interrupts
// - mode field encodes four modes
// - prescaler divides by two to field
// - edge bits select rising when one
// - counter resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "mft_consts.svh"

module multi_function_timer
  import mft_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // cpu register port
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // timer pins
  input wire logic capture_a_i,
  input wire logic capture_b_i,
  input wire logic event_clk_i,
  output logic timer_out_o,
  output logic irq_o
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] event_ctrl;
  logic [7:0] setup_ctrl;
  logic [CNT_W-1:0] cmp_a;
  logic [CNT_W-1:0] cmp_b;
  logic [CNT_W-1:0] capture_reg;
  logic [CNT_W-1:0] count;
  logic active_b;
  mode_e mode;
  logic [2:0] prescale;
  logic capture_edge_select;
  logic event_clock_edge_select;
  logic is_cap;
  assign mode = mode_e'(setup_ctrl[`SU_MODE_HI:`SU_MODE_LO]);
  assign prescale = setup_ctrl[`SU_PRESCALE_HI:`SU_PRESCALE_LO];
  assign capture_edge_select = setup_ctrl[`SU_CAPTURE_EDGE];
  assign event_clock_edge_select = setup_ctrl[`SU_EVENT_EDGE];
  assign is_cap = (mode == MODE_CAPTURE);
  logic wr_event;
  logic wr_setup;
  assign wr_event = reg_wr_i && (reg_sel_i == `SEL_EVENT_CTRL);
  assign wr_setup = reg_wr_i && (reg_sel_i == `SEL_SETUP_CTRL);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      setup_ctrl <= `RST_SETUP_CTRL;
    end else if (wr_setup) begin
      setup_ctrl <= {1'b0, reg_wdata_i[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // prescaler and edge detection
  // ----------------------------------------------------------------
  logic [6:0] pre_cnt;
  logic [6:0] pre_mask;
  logic pre_tick;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // same three-bit field in capture mode
  // divide by two to the field value
  assign pre_mask = 7'((8'h01 << prescale) - 8'h01);
  assign pre_tick = ((pre_cnt & pre_mask) == pre_mask);
  // bit 0 capture a, bit 1 capture b, bit 2 event clock
  logic [2:0] pins;
  logic [2:0] pins_prev;
  logic [2:0] rise_sel;
  logic [2:0] edges;
  assign pins = {event_clk_i, capture_b_i, capture_a_i};
  assign rise_sel = {event_clock_edge_select, capture_edge_select,
                     capture_edge_select};
  // pins are already synchronous; edge selects reset to falling, so a high
  // pin at reset release shows no edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev <= 3'h0;
    end else begin
      pins_prev <= pins;
    end
  end
  assign edges = (rise_sel & pins & ~pins_prev)
               | (~rise_sel & ~pins & pins_prev);

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  logic tick;
  logic [CNT_W-1:0] active_cmp;
  logic match_reload;
  logic match_free;
  logic wrap;
  logic cap_a_ev;
  logic cap_b_ev;
  // event mode advances on pin edges
  assign tick = (mode == MODE_EVENT) ? edges[2] : pre_tick;
  assign active_cmp = active_b ? cmp_b : cmp_a;
  assign match_reload = tick && !is_cap && (count == active_cmp);
  assign match_free = tick && is_cap && (count == cmp_a);
  // a reload at the max value wins, so no wrap then
  assign wrap = tick && (&count) && !match_reload;
  assign cap_a_ev = is_cap && edges[0];
  assign cap_b_ev = is_cap && edges[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count <= CNT_W'(`RST_COUNT);
      active_b <= 1'b0;
    end else if (match_reload) begin
      count <= '0;
      active_b <= !active_b;
    end else if (tick) begin
      count <= CNT_W'(count + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_out_o <= 1'b0;
    end else begin
      unique case (mode)
        // pwm and event modes toggle on match
        MODE_PWM, MODE_EVENT: begin
          if (match_reload) begin
            timer_out_o <= !timer_out_o;
          end
        end
        // capture mode toggles on compare a
        MODE_CAPTURE: begin
          if (match_free) begin
            timer_out_o <= !timer_out_o;
          end
        end
        // software timer leaves the pin alone
        MODE_SOFT: timer_out_o <= timer_out_o;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // compare and capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a <= CNT_W'(`RST_COMPARE);
    end else if (reg_wr_i && reg_sel_i == `SEL_COMPARE_A) begin
      cmp_a <= reg_wdata_i[CNT_W-1:0];
    end
  end

  // capture beats a software write landing in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmp_b <= CNT_W'(`RST_COMPARE);
    end else if (cap_b_ev) begin
      cmp_b <= count;
    end else if (reg_wr_i && reg_sel_i == `SEL_COMPARE_B) begin
      cmp_b <= reg_wdata_i[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_reg <= CNT_W'(`RST_COMPARE);
    end else if (cap_a_ev) begin
      capture_reg <= count;
    end
  end

  // ----------------------------------------------------------------
  // event flags and enables
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_mask;
  // bit layout of the event register
  // compare flags follow the active register
  // capture flags only in capture mode
  assign flag_set = {cap_b_ev, cap_a_ev, 1'b0,
                     match_reload && active_b,
                     (match_reload && !active_b) || match_free,
                     1'b0, wrap, 1'b0};
  assign flag_mask = 8'hda;
  // write zero clears, a set wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      event_ctrl <= `RST_EVENT_CTRL;
    end else if (wr_event) begin
      event_ctrl <= ((event_ctrl & reg_wdata_i[7:0]) | flag_set) & flag_mask
                  | (reg_wdata_i[7:0] & ~flag_mask);
    end else begin
      event_ctrl <= event_ctrl | flag_set;
    end
  end

  // capture flags gated by capture enable
  // compare flags gated by compare enable
  // wrap flag gated by wrap enable
  // any enabled pending flag raises irq
  assign irq_o = (event_ctrl[`EV_CAPTURE_IRQ_EN]
                  && (event_ctrl[`EV_CAPTURE_A_FLAG]
                      || event_ctrl[`EV_CAPTURE_B_FLAG]))
              || (event_ctrl[`EV_COMPARE_IRQ_EN]
                  && (event_ctrl[`EV_COMPARE_A_FLAG]
                      || event_ctrl[`EV_COMPARE_B_FLAG]))
              || (event_ctrl[`EV_WRAP_IRQ_EN]
                  && event_ctrl[`EV_WRAP_FLAG]);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_sel_i)
      `SEL_EVENT_CTRL: next_rdata = {8'h00, event_ctrl};
      `SEL_SETUP_CTRL: next_rdata = {8'h00, setup_ctrl};
      `SEL_COMPARE_A: next_rdata[CNT_W-1:0] = cmp_a;
      `SEL_COMPARE_B: next_rdata[CNT_W-1:0] = cmp_b;
      `SEL_CAPTURE: next_rdata[CNT_W-1:0] = capture_reg;
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  // a match at count zero keeps the counter there for one more tick
  chk_pwm_restart: assert property (
    match_reload |=> count == '0 ##1
      (($past(tick) && !$past(match_reload)) -> count == CNT_W'(1)))
    else $error("counter did not restart after match");
  chk_active_swap: assert property (
    match_reload |=> active_b != $past(active_b))
    else $error("active compare did not alternate");
  chk_prescale_tick: assert property (
    (mode != MODE_EVENT && prescale == 3'h0) |-> tick)
    else $error("divide by one missed a tick");
  chk_soft_quiet: assert property (
    (mode == MODE_SOFT) ##1 (mode == MODE_SOFT) |-> $stable(timer_out_o))
    else $error("software timer toggled output");
  chk_event_edge: assert property (
    (mode == MODE_EVENT && !edges[2]) |=> $stable(count))
    else $error("event counter moved without edge");
  chk_free_run: assert property (
    (tick && is_cap) |=> count == CNT_W'($past(count) + 1'b1))
    else $error("capture mode counter not free running");
  chk_match_toggle: assert property (
    match_free |=> timer_out_o != $past(timer_out_o)
      && event_ctrl[`EV_COMPARE_A_FLAG])
    else $error("compare a match not handled");
  chk_capture_a: assert property (
    cap_a_ev |=> capture_reg == $past(count)
      && event_ctrl[`EV_CAPTURE_A_FLAG])
    else $error("capture a not recorded");
  chk_capture_b: assert property (
    cap_b_ev |=> cmp_b == $past(count))
    else $error("capture b not loaded into compare b");
  chk_wrap_flag: assert property (
    wrap |=> event_ctrl[`EV_WRAP_FLAG] && count == '0)
    else $error("wrap did not set its flag");
  chk_set_wins: assert property (
    (wrap && wr_event && !reg_wdata_i[`EV_WRAP_FLAG])
      |=> event_ctrl[`EV_WRAP_FLAG])
    else $error("clear beat a simultaneous set");
  chk_cmp_set_wins: assert property (
    (match_reload && wr_event
      && reg_wdata_i[`EV_COMPARE_B_FLAG:`EV_COMPARE_A_FLAG] == 2'b00)
      |=> event_ctrl[$past(active_b) ? `EV_COMPARE_B_FLAG
                                     : `EV_COMPARE_A_FLAG])
    else $error("clear beat a simultaneous compare set");
  chk_flag_sticky: assert property (
    (event_ctrl[`EV_CAPTURE_B_FLAG] && !wr_event)
      |=> event_ctrl[`EV_CAPTURE_B_FLAG])
    else $error("capture flag dropped by itself");
  chk_wrap_irq: assert property (
    (event_ctrl[`EV_WRAP_FLAG] && event_ctrl[`EV_WRAP_IRQ_EN]) |-> irq_o)
    else $error("enabled wrap flag without irq");

  cov_pwm_cycle: cover property (
    mode == MODE_PWM && match_reload && !active_b
      ##[1:300] match_reload && active_b);
  cov_capture_both: cover property (cap_a_ev ##[1:100] cap_b_ev);
  cov_wrap: cover property (wrap && is_cap);
  cov_event_match: cover property (mode == MODE_EVENT && match_reload);

endmodule : multi_function_timer
`default_nettype wire

// File: verification/pin_source.sv
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  // clock
  input wire logic clk_i,
  // pins toward the timer
  output var logic capture_a_o,
  output var logic capture_b_o,
  output var logic event_clk_o
);
  // -----------------------------------------------------------
  // level driver
  // -----------------------------------------------------------
  // pins idle low so no stray edge shows at reset release
  initial begin
    capture_a_o = 1'b0;
    capture_b_o = 1'b0;
    event_clk_o = 1'b0;
  end

  // back to back calls hold each level exactly n cycles
  task automatic step(input logic [2:0] v, input int n);
    @(negedge clk_i);
    {event_clk_o, capture_b_o, capture_a_o} = v;
    repeat (n - 1) @(negedge clk_i);
  endtask : step
endmodule : pin_source

`default_nettype wire

// File: verification/test_multi_function_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mft_consts.svh"

module test_multi_function_timer;
  import mft_pkg::*;
  localparam int LIMIT = 95000;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] reg_sel_i = 3'h0;
  logic reg_wr_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  wire logic capture_a_i;
  wire logic capture_b_i;
  wire logic event_clk_i;
  logic timer_out_o;
  logic irq_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  multi_function_timer #(.CNT_W(16)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .capture_a_i(capture_a_i),
    .capture_b_i(capture_b_i), .event_clk_i(event_clk_i),
    .timer_out_o(timer_out_o), .irq_o(irq_o)
  );
  pin_source u_src (
    .clk_i(clk_i), .capture_a_o(capture_a_i),
    .capture_b_o(capture_b_i), .event_clk_o(event_clk_i)
  );

  always #50 clk_i = ~clk_i;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(negedge clk_i);
    reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  // read data is registered, so look one cycle after the select
  task automatic rd(input logic [2:0] s, output logic [15:0] d);
    @(negedge clk_i);
    reg_sel_i = s;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic rchk(input logic [2:0] s, input logic [15:0] exp);
    logic [15:0] d;
    rd(s, d);
    chk(d, exp);
  endtask : rchk

  task automatic do_reset();
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask : do_reset

  task automatic wait_edge(output int t);
    logic v;
    v = timer_out_o;
    t = -1;
    for (int i = 0; i < 3000 && t < 0; i++) begin
      @(posedge clk_i);
      #1;
      if (timer_out_o !== v) t = cyc;
    end
    chk(16'(t >= 0), 16'h0001);
  endtask : wait_edge

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic run_pwm(input mode_e m, input int p);
    logic [15:0] a;
    logic [15:0] b;
    int t0;
    int t1;
    int t2;
    a = 16'($urandom_range(5, 1));
    b = 16'($urandom_range(5, 1));
    do_reset();
    wr(`SEL_COMPARE_A, a);
    wr(`SEL_COMPARE_B, b);
    wr(`SEL_EVENT_CTRL, 16'h0004);
    wr(`SEL_SETUP_CTRL, 16'({p[2:0], m}));
    if (m == MODE_SOFT) begin
      repeat (60) begin
        @(negedge clk_i);
        chk({15'h0, timer_out_o}, 16'h0000);
      end
    end else begin
      wait_edge(t0);
      wait_edge(t1);
      wait_edge(t2);
      // the first toggle may come from either compare, so the two
      // intervals are pinned down by their sum and their product
      t0 = t1 - t0;
      t1 = t2 - t1;
      chk(16'(t0 + t1), 16'((a + b + 16'h2) << p));
      chk(16'(t0 * t1 == (a + 1) * (b + 1) << 2 * p), 16'h0001);
    end
    rchk(`SEL_EVENT_CTRL, 16'h001c);
    chk({15'h0, irq_o}, 16'h0001);
    wr(`SEL_EVENT_CTRL, 16'h0000);
    chk({15'h0, irq_o}, 16'h0000);
  endtask : run_pwm

  task automatic run_event(input logic e);
    do_reset();
    wr(`SEL_SETUP_CTRL, 16'({e, 5'h03}));
    wr(`SEL_COMPARE_A, 16'h0002);
    wr(`SEL_COMPARE_B, 16'h0002);
    // three rising and two falling edges
    for (int i = 0; i < 5; i++) u_src.step({~i[0], 2'b00}, 8);
    chk({15'h0, timer_out_o}, {15'h0, e});
    u_src.step(3'b000, 8);
    chk({15'h0, timer_out_o}, 16'h0001);
  endtask : run_event

  task automatic run_cap(input logic e);
    logic [15:0] c1;
    logic [15:0] c2;
    int w;
    int w2;
    int t1;
    int t2;
    w = $urandom_range(9, 2);
    w2 = $urandom_range(19, 10);
    do_reset();
    wr(`SEL_SETUP_CTRL, 16'({e, 6'h02}));
    wr(`SEL_COMPARE_A, 16'h0100);
    wr(`SEL_EVENT_CTRL, 16'h0020);
    repeat (300) @(negedge clk_i);
    rchk(`SEL_EVENT_CTRL, 16'h0028);
    chk({15'h0, timer_out_o}, 16'h0000);
    @(negedge clk_i);
    t1 = cyc;
    u_src.step(3'b001, w);
    u_src.step(3'b010, w2);
    u_src.step(3'b000, 4);
    rd(`SEL_CAPTURE, c1);
    rd(`SEL_COMPARE_B, c2);
    chk(c2 - c1, 16'(e ? w : w2));
    chk(16'(c1 > 16'h0100 && c1 < 16'h0200), 16'h0001);
    rchk(`SEL_EVENT_CTRL, 16'h00e8);
    chk({15'h0, irq_o}, 16'h0001);
    wr(`SEL_EVENT_CTRL, 16'h0020);
    rchk(`SEL_EVENT_CTRL, 16'h0020);
    chk({15'h0, irq_o}, 16'h0000);
    if (e) begin
      wr(`SEL_EVENT_CTRL, 16'h0001);
      for (int i = 0; i < 70000 && irq_o !== 1'b1; i++) @(negedge clk_i);
      rchk(`SEL_EVENT_CTRL, 16'h0003);
      wr(`SEL_EVENT_CTRL, 16'h0002);
      chk({15'h0, irq_o}, 16'h0000);
      @(negedge clk_i);
      t2 = cyc;
      u_src.step(3'b001, 4);
      u_src.step(3'b000, 4);
      rd(`SEL_CAPTURE, c2);
      // one wrap counted between the captures
      chk(16'(65536 + int'(c2) - int'(c1) == t2 - t1), 16'h0001);
    end
  endtask : run_cap

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    void'($urandom(66571));
    do_reset();
    // compares at zero match the reset count on every tick
    for (int s = 0; s < 8; s++) rchk(3'(s), s ? 16'h0000 : 16'h0018);
    wr(`SEL_EVENT_CTRL, 16'h0000);
    rchk(`SEL_EVENT_CTRL, 16'h0018);
    wr(`SEL_CAPTURE, 16'hbeef);
    rchk(`SEL_CAPTURE, 16'h0000);
    wr(`SEL_SETUP_CTRL, 16'h00ff);
    rchk(`SEL_SETUP_CTRL, 16'h007f);
    run_pwm(MODE_SOFT, 0);
    for (int p = 0; p < 8; p++) run_pwm(MODE_PWM, p);
    run_event(1'b1);
    run_event(1'b0);
    run_cap(1'b0);
    run_cap(1'b1);
    end_sim();
  end
endmodule : test_multi_function_timer

`default_nettype wire
